// >>> common/mdma_pkg.sv
package mdma_pkg;
	// ==========================================================
	// geometry
	localparam int NCH = 8;
	localparam int NFL = 3;
	// ==========================================================
	// register map, byte addresses
	localparam logic [7:0] A_ISR = 8'h00;
	localparam logic [7:0] A_IMR = 8'h04;
	localparam logic [7:0] A_SWT = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0C;
	localparam logic [3:0] O_CFG = 4'h0;
	localparam logic [3:0] O_SRC = 4'h4;
	localparam logic [3:0] O_DST = 4'h8;
	localparam logic [3:0] O_CNT = 4'hC;
	// channel n sits at 0x80 + 0x10*n, address bit 7 selects it
	localparam int CH_SEL_BIT = 7;
	// ==========================================================
	// fields and codes
	localparam logic [1:0] SZ_B = 2'h0;
	localparam logic [1:0] SZ_H = 2'h1;
	localparam logic [1:0] SZ_W = 2'h2;
	localparam int F_HT = 0;
	localparam int F_TC = 1;
	localparam int F_TE = 2;
	localparam logic [16:0] CNT_MAX = 17'h10000;
	// ram window used for the memory-to-memory check
	localparam logic [31:0] RAM_BASE = 32'h2000_0000;
	localparam logic [31:0] RAM_MASK = 32'hFFFF_0000;
	// ==========================================================
	// reset values
	localparam logic [31:0] ADDR_RST = 32'h0000_0000;
	localparam logic [16:0] CNT_RST = 17'h00000;
	localparam logic [2:0] FILL_RST = 3'h0;
	// ==========================================================
	// types
	typedef struct packed {
		logic m2m;
		logic dinc;
		logic sinc;
		logic [1:0] dsz;
		logic [1:0] ssz;
		logic [1:0] prio;
		logic circ;
		logic sw;
		logic en;
	} mdma_cfg_t;
	localparam mdma_cfg_t CFG_RST = 12'h000;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0] be;
		logic rd;
		logic wr;
	} mdma_mreq_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_RD = 3'h2,
		ST_WR = 3'h4
	} mdma_state_t;
endpackage : mdma_pkg

// >>> hdl/mdma_arb.sv
`timescale 1ns/1ps
module mdma_arb
	import mdma_pkg::*;
(
	// requests and their levels
	input wire logic [NCH-1:0] req_i,
	input wire logic [2*NCH-1:0] prio_i,
	// winner
	output logic gnt_vld_o,
	output logic [2:0] gnt_o
);
	logic [1:0] best;
	always_comb begin
		best = 2'h0;
		gnt_vld_o = 1'b0;
		gnt_o = 3'h0;
		for (int i = 0; i < NCH; i++) begin
			// strict compare keeps lower number on ties
			if (req_i[i] && (!gnt_vld_o || prio_i[2*i +: 2] > best)) begin
				gnt_vld_o = 1'b1;
				best = prio_i[2*i +: 2];
				gnt_o = 3'(i);
			end
		end
	end
endmodule : mdma_arb

// >>> hdl/mdma_top.sv
// What this block does
// - eight channels, each with its own configuration and its own request input.
// - a channel is started either by its hardware request or by a software trigger, chosen per channel; a memory-to-memory channel starts on enable.
// - each channel has a four-level priority and the highest pending level is served first.
// - among equal levels the lower channel number is served first.
// - source and destination sizes are independent and unequal sizes are packed or unpacked.
// - a circular channel restarts over the same buffer instead of stopping.
// - half transfer, complete and error flags per channel are ORed into one interrupt per channel.
// - memory-to-memory runs only when both ends lie in ram, else it ends in error.
// - peripheral-to-memory, memory-to-peripheral and peripheral-to-peripheral moves are all allowed.
// - ram and peripheral space may each be source or destination.
// - the item count is programmable up to 65536.
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module mdma_top
	import mdma_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// register slave
	input wire logic [7:0] s_address_i,
	input wire logic s_read_i,
	input wire logic s_write_i,
	input wire logic [31:0] s_writedata_i,
	output logic [31:0] s_readdata_o,
	output logic s_waitrequest_o,
	// data master
	output logic [31:0] m_address_o,
	output logic m_read_o,
	output logic m_write_o,
	output logic [31:0] m_writedata_o,
	output logic [3:0] m_byteenable_o,
	input wire logic [31:0] m_readdata_i,
	input wire logic m_waitrequest_i,
	// peripheral requests, asynchronous
	input wire logic [NCH-1:0] dma_req_i,
	// interrupts
	output logic [NCH-1:0] irq_ch_o,
	output logic irq_o
);
	// ==========================================================
	// helpers
	function automatic logic [2:0] nbytes(input logic [1:0] s);
		return (s == SZ_W) ? 3'h4 : (s == SZ_H) ? 3'h2 : 3'h1;
	endfunction : nbytes
	function automatic logic [31:0] bmask(input logic [2:0] n);
		return (n == 3'h4) ? 32'hFFFF_FFFF : (n == 3'h2) ? 32'h0000_FFFF : 32'h0000_00FF;
	endfunction : bmask
	function automatic logic [3:0] bemask(input logic [2:0] n);
		return (n == 3'h4) ? 4'hF : (n == 3'h2) ? 4'h3 : 4'h1;
	endfunction : bemask
	function automatic logic in_ram(input logic [31:0] a);
		return (a & RAM_MASK) == RAM_BASE;
	endfunction : in_ram

	// ==========================================================
	// state
	// per-channel configuration
	mdma_cfg_t cfg_reg [NCH];
	logic [31:0] src_reg [NCH];
	logic [31:0] dst_reg [NCH];
	logic [16:0] ndt_reg [NCH];
	logic [31:0] csrc_reg [NCH];
	logic [31:0] cdst_reg [NCH];
	logic [16:0] rem_reg [NCH];
	logic [31:0] buf_reg [NCH];
	logic [2:0] fill_reg [NCH];
	logic [NCH-1:0] sw_pend_reg;
	logic [NCH-1:0] hw_pend_reg;
	logic [NFL*NCH-1:0] isr_reg;
	logic [NFL*NCH-1:0] imr_reg;
	mdma_state_t st_reg;
	logic [2:0] ch_reg;
	mdma_mreq_t mreq_reg;
	logic [NFL-1:0] ev_reg;
	logic [2:0] ev_ch_reg;
	logic dis_reg;
	logic item_done;
	// a read beat accepted at this edge consumes its hardware request at once,
	// so the idle cycle after it cannot start a second read on the old request
	assign item_done = (st_reg == ST_RD) && !m_waitrequest_i;

	// ==========================================================
	// slave decode
	logic acc;
	logic wr_acc;
	logic ch_hit;
	logic [2:0] s_ch;
	logic [3:0] s_off;
	logic [NCH-1:0] load_vec;
	logic [31:0] rd_mux;
	assign acc = (s_read_i || s_write_i) && !s_waitrequest_o;
	assign wr_acc = s_write_i && acc;
	assign ch_hit = s_address_i[CH_SEL_BIT];
	assign s_ch = s_address_i[6:4];
	assign s_off = s_address_i[3:0];

	// one wait cycle, then the answer
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_waitrequest_o <= 1'b1;
			s_readdata_o <= 32'h0000_0000;
		end else begin
			s_waitrequest_o <= !((s_read_i || s_write_i) && s_waitrequest_o);
			s_readdata_o <= rd_mux;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (ch_hit) begin
			case (s_off)
				O_CFG: rd_mux = {20'h00000, cfg_reg[s_ch]};
				O_SRC: rd_mux = src_reg[s_ch];
				O_DST: rd_mux = dst_reg[s_ch];
				// remaining items, not the programmed figure
				O_CNT: rd_mux = {15'h0000, rem_reg[s_ch]};
				default: rd_mux = 32'h0000_0000;
			endcase
		end else begin
			case (s_address_i)
				A_ISR: rd_mux = {8'h00, isr_reg};
				A_IMR: rd_mux = {8'h00, imr_reg};
				A_SWT: rd_mux = {24'h000000, sw_pend_reg};
				A_STAT: rd_mux = {25'h0000000, ch_reg, 1'b0, st_reg};
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// configuration registers
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_cfg
			logic hit;
			assign hit = wr_acc && ch_hit && (s_ch == 3'(g));
			// enable rising from software loads the working copy
			assign load_vec[g] = hit && (s_off == O_CFG) && s_writedata_i[0] && !cfg_reg[g].en;
			always_ff @(posedge clock_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					cfg_reg[g] <= CFG_RST;
					src_reg[g] <= ADDR_RST;
					dst_reg[g] <= ADDR_RST;
					ndt_reg[g] <= CNT_RST;
				end else begin
					if (hit && s_off == O_CFG) begin
						cfg_reg[g] <= mdma_cfg_t'(s_writedata_i[11:0]);
					end else if (dis_reg && ev_ch_reg == 3'(g)) begin
						cfg_reg[g].en <= 1'b0;
					end
					// low address bits are used as given
					if (hit && s_off == O_SRC) begin
						src_reg[g] <= s_writedata_i;
					end
					if (hit && s_off == O_DST) begin
						dst_reg[g] <= s_writedata_i;
					end
					// zero to 65536, larger values saturate
					if (hit && s_off == O_CNT) begin
						ndt_reg[g] <= (s_writedata_i > 32'h0001_0000) ? CNT_MAX : s_writedata_i[16:0];
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// requests, triggers, flags
	logic [NCH-1:0] req_m_reg;
	logic [NCH-1:0] req_s_reg;
	logic [NCH-1:0] req_d_reg;
	logic [NCH-1:0] ready;
	logic [2*NCH-1:0] prio_vec;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			req_m_reg <= 8'h00;
			req_s_reg <= 8'h00;
			req_d_reg <= 8'h00;
		end else begin
			req_m_reg <= dma_req_i;
			req_s_reg <= req_m_reg;
			req_d_reg <= req_s_reg;
		end
	end

	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			mdma_cfg_t c;
			logic [2:0] db;
			logic trig;
			assign c = cfg_reg[g];
			assign db = nbytes(c.dsz);
			// start source chosen by the sw bit, memory-to-memory starts without either
			assign trig = c.m2m || (c.sw ? sw_pend_reg[g] : hw_pend_reg[g]);
			assign ready[g] = c.en && (trig || fill_reg[g] >= db || rem_reg[g] == CNT_RST);
			assign prio_vec[2*g +: 2] = c.prio;

			always_ff @(posedge clock_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					hw_pend_reg[g] <= 1'b0;
					sw_pend_reg[g] <= 1'b0;
				end else begin
					// one rising request moves one source item, new edge wins
					if (req_s_reg[g] && !req_d_reg[g]) begin
						hw_pend_reg[g] <= 1'b1;
					end else if (item_done && ch_reg == 3'(g)) begin
						hw_pend_reg[g] <= 1'b0;
					end
					if (wr_acc && !ch_hit && s_address_i == A_SWT && s_writedata_i[g]) begin
						sw_pend_reg[g] <= 1'b1;
					end else if (dis_reg && ev_ch_reg == 3'(g)) begin
						sw_pend_reg[g] <= 1'b0;
					end
				end
			end

			// three sticky flags per channel, write one to clear, set wins
			for (genvar f = 0; f < NFL; f++) begin : g_fl
				always_ff @(posedge clock_i or negedge rst_b_i) begin
					if (!rst_b_i) begin
						isr_reg[NFL*g+f] <= 1'b0;
					end else if (ev_reg[f] && ev_ch_reg == 3'(g)) begin
						isr_reg[NFL*g+f] <= 1'b1;
					end else if (wr_acc && !ch_hit && s_address_i == A_ISR && s_writedata_i[NFL*g+f]) begin
						isr_reg[NFL*g+f] <= 1'b0;
					end
				end
			end

			// flags of one channel ORed into its line
			always_ff @(posedge clock_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					irq_ch_o[g] <= 1'b0;
				end else begin
					irq_ch_o[g] <= |(isr_reg[NFL*g +: NFL] & imr_reg[NFL*g +: NFL]);
				end
			end
		end
	endgenerate

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			imr_reg <= 24'h000000;
			irq_o <= 1'b0;
		end else begin
			if (wr_acc && !ch_hit && s_address_i == A_IMR) begin
				imr_reg <= s_writedata_i[NFL*NCH-1:0];
			end
			irq_o <= |(isr_reg & imr_reg);
		end
	end

	// ==========================================================
	// arbitration
	logic gnt_vld;
	logic [2:0] gnt;
	mdma_arb u_arb (
		.req_i(ready),
		.prio_i(prio_vec),
		.gnt_vld_o(gnt_vld),
		.gnt_o(gnt)
	);

	// ==========================================================
	// transfer engine
	// re-arbitrates after every beat, so a high level never waits a whole block
	logic [2:0] k;
	mdma_cfg_t kc;
	logic [2:0] sb;
	logic [2:0] db;
	logic [31:0] rpiece;
	logic [16:0] rem_dec;
	logic bad;
	assign k = (st_reg == ST_IDLE) ? gnt : ch_reg;
	assign kc = cfg_reg[k];
	assign sb = nbytes(kc.ssz);
	assign db = nbytes(kc.dsz);
	assign rpiece = (m_readdata_i >> {csrc_reg[k][1:0], 3'h0}) & bmask(sb);
	assign rem_dec = rem_reg[k] - 17'h00001;
	// memory-to-memory needs both ends in ram
	assign bad = (kc.ssz == 2'h3) || (kc.dsz == 2'h3)
		|| (kc.m2m && !(in_ram(csrc_reg[k]) && in_ram(cdst_reg[k])));

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg <= ST_IDLE;
			ch_reg <= 3'h0;
			mreq_reg <= '0;
			ev_reg <= 3'h0;
			ev_ch_reg <= 3'h0;
			dis_reg <= 1'b0;
			for (int i = 0; i < NCH; i++) begin
				csrc_reg[i] <= ADDR_RST;
				cdst_reg[i] <= ADDR_RST;
				rem_reg[i] <= CNT_RST;
				buf_reg[i] <= ADDR_RST;
				fill_reg[i] <= FILL_RST;
			end
		end else begin
			ev_reg <= 3'h0;
			dis_reg <= 1'b0;
			for (int i = 0; i < NCH; i++) begin
				if (load_vec[i]) begin
					csrc_reg[i] <= src_reg[i];
					cdst_reg[i] <= dst_reg[i];
					rem_reg[i] <= ndt_reg[i];
					fill_reg[i] <= FILL_RST;
					buf_reg[i] <= ADDR_RST;
				end
			end
			case (st_reg)
				ST_IDLE: begin
					if (gnt_vld) begin
						ch_reg <= gnt;
						ev_ch_reg <= gnt;
						if (bad) begin
							ev_reg[F_TE] <= 1'b1;
							dis_reg <= 1'b1;
						end else if (fill_reg[k] >= db) begin
							// enough packed bytes for one destination beat
							mreq_reg.addr <= {cdst_reg[k][31:2], 2'h0};
							mreq_reg.data <= (buf_reg[k] & bmask(db)) << {cdst_reg[k][1:0], 3'h0};
							mreq_reg.be <= bemask(db) << cdst_reg[k][1:0];
							mreq_reg.wr <= 1'b1;
							st_reg <= ST_WR;
						end else if (rem_reg[k] == CNT_RST) begin
							ev_reg[F_TC] <= 1'b1;
							fill_reg[k] <= FILL_RST;
							buf_reg[k] <= ADDR_RST;
							if (kc.circ) begin
								csrc_reg[k] <= src_reg[k];
								cdst_reg[k] <= dst_reg[k];
								rem_reg[k] <= ndt_reg[k];
							end else begin
								dis_reg <= 1'b1;
							end
						end else begin
							// any address space on either side
							mreq_reg.addr <= {csrc_reg[k][31:2], 2'h0};
							mreq_reg.be <= bemask(sb) << csrc_reg[k][1:0];
							mreq_reg.rd <= 1'b1;
							st_reg <= ST_RD;
						end
					end
				end
				ST_RD: begin
					if (!m_waitrequest_i) begin
						mreq_reg.rd <= 1'b0;
						// append source bytes to the packing buffer
						buf_reg[k] <= buf_reg[k] | (rpiece << {fill_reg[k], 3'h0});
						fill_reg[k] <= fill_reg[k] + sb;
						rem_reg[k] <= rem_dec;
						if (kc.sinc) begin
							csrc_reg[k] <= csrc_reg[k] + {29'h00000000, sb};
						end
						if (rem_dec == (ndt_reg[k] >> 1)) begin
							ev_reg[F_HT] <= 1'b1;
						end
						st_reg <= ST_IDLE;
					end
				end
				ST_WR: begin
					if (!m_waitrequest_i) begin
						mreq_reg.wr <= 1'b0;
						// unpack, drop the bytes just written
						buf_reg[k] <= buf_reg[k] >> {db, 3'h0};
						fill_reg[k] <= fill_reg[k] - db;
						if (kc.dinc) begin
							cdst_reg[k] <= cdst_reg[k] + {29'h00000000, db};
						end
						st_reg <= ST_IDLE;
					end
				end
				default: begin
					mreq_reg <= '0;
					st_reg <= ST_IDLE;
				end
			endcase
		end
	end

	assign m_address_o = mreq_reg.addr;
	assign m_read_o = mreq_reg.rd;
	assign m_write_o = mreq_reg.wr;
	assign m_writedata_o = mreq_reg.data;
	assign m_byteenable_o = mreq_reg.be;
endmodule : mdma_top

// >>> bench/mdma_top_assertions.sv
`timescale 1ns/1ps
module mdma_top_assertions
	import mdma_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// register slave
	input wire logic s_read_i,
	input wire logic s_write_i,
	input wire logic s_waitrequest_o,
	// data master
	input wire logic [31:0] m_address_o,
	input wire logic m_read_o,
	input wire logic m_write_o,
	input wire logic [31:0] m_writedata_o,
	input wire logic [3:0] m_byteenable_o,
	input wire logic m_waitrequest_i,
	// interrupts
	input wire logic [NCH-1:0] irq_ch_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);
	// ==========================================================
	// register slave
	chk_wait_one: assert property (
		(s_read_i || s_write_i) && s_waitrequest_o |=> !s_waitrequest_o) else $error("slave answer late");
	chk_wait_pulse: assert property (
		!s_waitrequest_o |=> s_waitrequest_o) else $error("waitrequest low too long");
	// ==========================================================
	// data master
	chk_rw_excl: assert property (
		!(m_read_o && m_write_o)) else $error("read and write together");
	chk_rd_hold: assert property (
		m_read_o && m_waitrequest_i |=> m_read_o && $stable(m_address_o)) else $error("read dropped in stall");
	chk_wr_hold: assert property (
		m_write_o && m_waitrequest_i |=> m_write_o && $stable({m_address_o, m_writedata_o, m_byteenable_o}))
		else $error("write changed in stall");
	chk_beat_gap: assert property (
		(m_read_o || m_write_o) && !m_waitrequest_i |=> !m_read_o && !m_write_o) else $error("no idle between beats");
	chk_lane_word: assert property (
		m_read_o || m_write_o |-> m_address_o[1:0] == 2'h0 && m_byteenable_o != 4'h0) else $error("bad beat lanes");
	// ==========================================================
	// interrupts
	chk_irq_or: assert property (
		irq_o == (|irq_ch_o)) else $error("summary irq mismatch");
endmodule : mdma_top_assertions

// >>> bench/mdma_mem_model.sv
`timescale 1ns/1ps
module mdma_mem_model (
	// clock
	input wire logic clock_i,
	// engine bus
	input wire logic [31:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [31:0] wd_i,
	input wire logic [3:0] be_i,
	input wire logic stall_i,
	// answer
	output logic [31:0] rdata_o,
	output logic wait_o
);
	logic [31:0] mem [0:255];
	logic [31:0] first;
	logic got = 1'h1;
	logic wait_q = 1'h1;
	logic [31:0] last = 32'h0;
	// ==========================================================
	// stalls and storage
	assign wait_o = wait_q;
	always @(posedge clock_i) begin
		wait_q <= stall_i;
	end
	always @(posedge clock_i) begin
		for (int b = 0; b < 4; b++) begin
			if (wr_i && !wait_q && be_i[b]) begin
				mem[addr_i[9:2]][8*b+:8] <= wd_i[8*b+:8];
			end
		end
		if (rd_i && !wait_q && !got) begin
			first <= addr_i;
			got <= 1'h1;
		end
		last <= rdata_o;
	end
	// released data flips every cycle so a stale word never passes
	assign rdata_o = rd_i ? mem[addr_i[9:2]] : ~last;
endmodule : mdma_mem_model

// >>> bench/mdma_top_tb.sv
`timescale 1ns/1ps
module mdma_top_tb
	import mdma_pkg::*;
;
	logic clock_i = 1'h0;
	logic rst_b_i = 1'h0;
	logic [7:0] s_adr = 8'h00;
	logic s_rd = 1'h0;
	logic s_wr = 1'h0;
	logic [31:0] s_wd = 32'h0;
	logic [31:0] s_q, m_adr, m_wd, m_q, q;
	logic s_wait, m_rd, m_wr, m_wait, irq, stall;
	logic [3:0] m_be;
	logic [NCH-1:0] dreq = 8'h00;
	logic [NCH-1:0] irq_ch;
	integer seed = 32'h10d204ae;
	int n_fail = 0;
	int n_checks = 0;
	initial stall = 1'h0;
	always #4 clock_i = ~clock_i;
	always @(posedge clock_i) stall <= ($random(seed) % 3) == 0;
	mdma_top DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .s_address_i(s_adr), .s_read_i(s_rd),
		.s_write_i(s_wr), .s_writedata_i(s_wd), .s_readdata_o(s_q), .s_waitrequest_o(s_wait),
		.m_address_o(m_adr), .m_read_o(m_rd), .m_write_o(m_wr), .m_writedata_o(m_wd),
		.m_byteenable_o(m_be), .m_readdata_i(m_q), .m_waitrequest_i(m_wait), .dma_req_i(dreq),
		.irq_ch_o(irq_ch), .irq_o(irq));
	mdma_mem_model mem_i (.clock_i(clock_i), .addr_i(m_adr), .rd_i(m_rd), .wr_i(m_wr), .wd_i(m_wd),
		.be_i(m_be), .stall_i(stall), .rdata_o(m_q), .wait_o(m_wait));
	// ==========================================================
	// helpers
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clock_i);
		s_adr <= a;
		s_wr <= w;
		s_rd <= !w;
		s_wd <= d;
		i = 0;
		do begin
			@(posedge clock_i);
			i++;
		end while (s_wait !== 1'b0 && i < 40);
		q = s_q;
		s_rd <= 1'h0;
		s_wr <= 1'h0;
		if (i >= 40) n_fail++;
	endtask : bus
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask : wr
	task rd(input logic [7:0] a);
		bus(1'h0, a, 32'h0);
	endtask : rd
	function logic [7:0] ca(input int ch, input logic [3:0] o);
		return {1'h1, 3'(ch), o};
	endfunction : ca
	function logic [31:0] cf(input logic m, si, di, input logic [1:0] ss, ds, pr, input logic ci, sw);
		return {20'h0, m, di, si, ds, ss, pr, ci, sw, 1'h1};
	endfunction : cf
	function logic [31:0] fld(input int ch);
		return {29'h0, q[3*ch+:3]};
	endfunction : fld
	task setup(input int ch, input logic [31:0] src, dst, cnt, c);
		wr(ca(ch, O_SRC), src);
		wr(ca(ch, O_DST), dst);
		wr(ca(ch, O_CNT), cnt);
		wr(ca(ch, O_CFG), c);
	endtask : setup
	task wflag(input int n);
		int i;
		i = 0;
		do begin
			rd(A_ISR);
			i++;
		end while (q[n] !== 1'b1 && i < 300);
	endtask : wflag
	task pulse(input int ch);
		@(posedge clock_i);
		dreq[ch] <= 1'h1;
		repeat (4) @(posedge clock_i);
		dreq[ch] <= 1'h0;
	endtask : pulse
	task results;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results
	// ==========================================================
	// tests
	initial begin
		repeat (40000) @(posedge clock_i);
		n_fail++;
		results();
	end
	initial begin
		for (int k = 0; k < 8; k++) mem_i.mem[k] = $random(seed);
		repeat (10) @(posedge clock_i);
		rst_b_i <= 1'h1;
		rd(A_STAT);
		chk("state", {29'h0, q[2:0]}, 32'h1);
		rd(A_IMR);
		chk("mask", q, 32'h0);
		rd(ca(3, O_CFG));
		chk("cfg", q, 32'h0);
		wr(8'h40, $random(seed));
		rd(8'h40);
		chk("hole", q, 32'h0);
		$display("test reset done");
		wr(A_IMR, 32'h00FF_FFFF);
		for (int k = 0; k < 9; k++) begin
			setup(k % 8, RAM_BASE, RAM_BASE + 32'h40 + 32'(8 * k), 32'(8 >> (k / 3)),
				cf(1'h1, 1'h1, 1'h1, 2'(k / 3), 2'(k % 3), 2'h0, 1'h0, 1'h0));
			wflag(3 * (k % 8) + F_TC);
			chk("flags", fld(k % 8), 32'h3);
			rd(ca(k % 8, O_CFG));
			chk("stop", {31'h0, q[0]}, 32'h0);
			chk("irq", {31'h0, irq_ch[k % 8]}, 32'h1);
			chk("irq all", {31'h0, irq}, 32'h1);
			chk("lo", mem_i.mem[16 + 2 * k], mem_i.mem[0]);
			chk("hi", mem_i.mem[17 + 2 * k], mem_i.mem[1]);
			wr(A_ISR, 32'h7 << (3 * (k % 8)));
		end
		$display("test sizes done");
		wr(A_IMR, 32'h00FF_FFC7);
		setup(1, 32'h4000_0000, RAM_BASE + 32'h100, 32'h2, cf(1'h1, 1'h1, 1'h1, SZ_W, SZ_W, 2'h0, 1'h0, 1'h0));
		wflag(3 + F_TE);
		chk("error", fld(1), 32'h4);
		chk("masked", {31'h0, irq_ch[1]}, 32'h0);
		wr(A_IMR, 32'h00FF_FFFF);
		rd(ca(1, O_CFG));
		chk("err stop", {31'h0, q[0]}, 32'h0);
		chk("unmask", {31'h0, irq_ch[1]}, 32'h1);
		wr(A_ISR, 32'h00FF_FFFF);
		rd(A_ISR);
		chk("clear", q, 32'h0);
		chk("irq off", {31'h0, irq}, 32'h0);
		$display("test error done");
		setup(5, 32'h4000_0000, RAM_BASE + 32'h100, 32'h2, cf(1'h0, 1'h0, 1'h1, SZ_W, SZ_W, 2'h1, 1'h0, 1'h0));
		pulse(5);
		wflag(15 + F_HT);
		rd(ca(5, O_CNT));
		chk("one item", q, 32'h1);
		pulse(5);
		wflag(15 + F_TC);
		chk("p2m a", mem_i.mem[64], mem_i.mem[0]);
		chk("p2m b", mem_i.mem[65], mem_i.mem[0]);
		setup(2, RAM_BASE, 32'h4000_0380, 32'h4, cf(1'h0, 1'h1, 1'h0, SZ_B, SZ_W, 2'h0, 1'h0, 1'h0));
		pulse(2);
		repeat (20) @(posedge clock_i);
		rd(ca(2, O_CNT));
		chk("pack one", q, 32'h3);
		repeat (3) begin
			pulse(2);
			repeat (20) @(posedge clock_i);
		end
		wflag(6 + F_TC);
		chk("pack", mem_i.mem[224], mem_i.mem[0]);
		setup(6, RAM_BASE + 32'h8, 32'h4000_0200, 32'h1, cf(1'h0, 1'h0, 1'h0, SZ_W, SZ_W, 2'h2, 1'h1, 1'h0));
		for (int r = 0; r < 2; r++) begin
			mem_i.mem[2] = $random(seed);
			wr(A_ISR, 32'h00FF_FFFF);
			pulse(6);
			wflag(18 + F_TC);
			rd(ca(6, O_CNT));
			chk("reload", q, 32'h1);
			rd(ca(6, O_CFG));
			chk("runs", {31'h0, q[0]}, 32'h1);
			chk("m2p", mem_i.mem[128], mem_i.mem[2]);
		end
		$display("test request done");
		for (int t = 0; t < 2; t++) begin
			setup(3, RAM_BASE + 32'hC, 32'h4000_0300, 32'h1, cf(1'h0, 1'h1, 1'h0, SZ_W, SZ_W, 2'(t), 1'h0, 1'h1));
			setup(4, RAM_BASE + 32'h10, 32'h4000_0300, 32'h1, cf(1'h0, 1'h1, 1'h0, SZ_W, SZ_W, t ? 2'h1 : 2'h3, 1'h0,
				1'h1));
			wr(A_ISR, 32'h00FF_FFFF);
			mem_i.got = 1'h0;
			wr(A_SWT, 32'h18);
			wflag(12 + F_TC);
			wflag(9 + F_TC);
			chk("winner", mem_i.first, t ? RAM_BASE + 32'hC : RAM_BASE + 32'h10);
		end
		$display("test priority done");
		results();
	end
endmodule : mdma_top_tb
bind mdma_top mdma_top_assertions chk_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .s_read_i(s_read_i),
	.s_write_i(s_write_i), .s_waitrequest_o(s_waitrequest_o), .m_address_o(m_address_o), .m_read_o(m_read_o),
	.m_write_o(m_write_o), .m_writedata_o(m_writedata_o), .m_byteenable_o(m_byteenable_o),
	.m_waitrequest_i(m_waitrequest_i), .irq_ch_o(irq_ch_o), .irq_o(irq_o));
